// file: pll_fb_ctrl.sv
`timescale 1ns/1ps
`include "pll_fb_params.svh"

module pll_fb_ctrl (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic HSEL,
  input wire logic [11:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic VCO_CLK,
  input wire logic REF_CLK,
  input wire logic CHAN_SYNC,
  output logic FB_PULSE,
  output logic PFD_REF_PULSE,
  output logic [8:0] CP_CURRENT,
  output logic RZERO_SHORT,
  output logic CPOLE_100PF,
  output logic SDM_POWERDOWN
);

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic logic is_mapped(input logic [9:0] idx);
    case (idx)
      `IDX_LOOP_CTRL, `IDX_CP_CURRENT, `IDX_REF_DIV, `IDX_CASC_LOW, `IDX_CASC_HIGH,
      `IDX_VCO_DIV, `IDX_FRAC_B0, `IDX_FRAC_B1, `IDX_FRAC_B2, `IDX_MOD_B0,
      `IDX_MOD_B1, `IDX_MOD_B2, `IDX_INT_DIV, `IDX_ZD_DIV, `IDX_STATUS:
        is_mapped = 1'b1;
      default:
        is_mapped = 1'b0;
    endcase
  endfunction

  function automatic pll_fb_pkg::ratio_t at_least(input pll_fb_pkg::ratio_t v,
                                                  input pll_fb_pkg::ratio_t lo);
    at_least = (v < lo) ? lo : v;
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  wire logic [2:0] sync_r;
  wire logic [2:0] prev_r;
  wire logic [2:0] pins;

  assign pins = {CHAN_SYNC, REF_CLK, VCO_CLK};

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_sync
      logic meta_r;
      logic stage2_r;
      logic last_r;
      assign sync_r[g] = stage2_r;
      assign prev_r[g] = last_r;
      always_ff @(posedge MCLK)
      begin
        if (RESET)
        begin
          meta_r <= 1'b0;
          stage2_r <= 1'b0;
          last_r <= 1'b0;
        end
        else
        begin
          meta_r <= pins[g];
          stage2_r <= meta_r;
          last_r <= stage2_r;
        end
      end
    end
  endgenerate

  // The VCO pin must toggle no faster than a quarter of MCLK to be counted.
  wire logic vco_rise = sync_r[0] & ~prev_r[0];
  wire logic ref_rise = sync_r[1] & ~prev_r[1];
  wire logic ref_fall = ~sync_r[1] & prev_r[1];
  wire logic sync_rise = sync_r[2] & ~prev_r[2];

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic sdm_pd_r;
  logic doubler_r;
  logic [3:0] ctrl_spare_r;
  pll_fb_pkg::loop_mode_t mode_r;
  logic [7:0] cp_r;
  logic [5:0] ref_div_r;
  logic [11:0] casc_r;
  logic [7:0] vco_div_r;
  pll_fb_pkg::word24_t frac_r;
  pll_fb_pkg::word24_t mod_r;
  logic [7:0] int_div_r;
  logic [6:0] zd_div_r;

  pll_fb_pkg::bus_state_t bus_r;
  pll_fb_pkg::bus_state_t bus_nxt;
  logic [9:0] idx_r;
  logic [31:0] rdata_r;

  wire logic accept = HSEL && HTRANS[1] && HREADY;
  wire logic do_write = (bus_r == pll_fb_pkg::BUS_WRITE) && is_mapped(idx_r);
  wire logic [7:0] wbyte = HWDATA[7:0];
  wire logic [7:0] rst_ctrl = `RST_LOOP_CTRL;
  wire logic [1:0] wmode = wbyte[`BIT_MODE_HI:`BIT_MODE_LO];
  wire logic [2:0] mode_bits = mode_r;
  wire logic [1:0] mode_code = (mode_bits == 3'b010) ? 2'b01 :
                               (mode_bits == 3'b100) ? 2'b10 : 2'b00;

  // A reserved code leaves the stored mode alone; the other bits still land.
  wire pll_fb_pkg::loop_mode_t mode_wr =
    (wmode == 2'b00) ? pll_fb_pkg::LOOP_FRAC :
    (wmode == 2'b01) ? pll_fb_pkg::LOOP_LOWPFD :
    (wmode == 2'b10) ? pll_fb_pkg::LOOP_ZD : mode_r;

  wire logic is_frac = mode_r == pll_fb_pkg::LOOP_FRAC;
  wire logic is_lowpfd = mode_r == pll_fb_pkg::LOOP_LOWPFD;
  wire logic is_zd = mode_r == pll_fb_pkg::LOOP_ZD;

  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      {ctrl_spare_r, doubler_r, sdm_pd_r} <= {rst_ctrl[7:4], rst_ctrl[3], rst_ctrl[0]};
      mode_r <= pll_fb_pkg::LOOP_FRAC;
      cp_r <= `RST_CP_CURRENT;
      ref_div_r <= `RST_REF_DIV;
      casc_r <= `RST_CASC_DIV;
      vco_div_r <= `RST_VCO_DIV;
      frac_r <= `RST_FRAC;
      mod_r <= `RST_MOD;
      int_div_r <= `RST_INT_DIV;
      zd_div_r <= `RST_ZD_DIV;
    end
    else if (do_write)
    begin
      case (idx_r)
        `IDX_LOOP_CTRL:
        begin
          sdm_pd_r <= wbyte[`BIT_SDM_PD];
          doubler_r <= wbyte[`BIT_DOUBLER];
          ctrl_spare_r <= wbyte[7:4];
          mode_r <= mode_wr;
        end
        `IDX_CP_CURRENT: cp_r <= wbyte;
        `IDX_REF_DIV: ref_div_r <= wbyte[5:0];
        `IDX_CASC_LOW: casc_r[7:0] <= wbyte;
        `IDX_CASC_HIGH: casc_r[11:8] <= wbyte[3:0];
        `IDX_VCO_DIV: vco_div_r <= wbyte;
        `IDX_FRAC_B0: frac_r[7:0] <= wbyte;
        `IDX_FRAC_B1: frac_r[15:8] <= wbyte;
        `IDX_FRAC_B2: frac_r[23:16] <= wbyte;
        `IDX_MOD_B0: mod_r[7:0] <= wbyte;
        `IDX_MOD_B1: mod_r[15:8] <= wbyte;
        `IDX_MOD_B2: mod_r[23:16] <= wbyte;
        `IDX_INT_DIV: int_div_r <= wbyte;
        `IDX_ZD_DIV: zd_div_r <= wbyte[6:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Feedback chain: stage A then stage B
  // ****************************************************************
  div_link stage_a ();
  div_link stage_b ();
  sdm_link sdm ();

  wire logic cfg_err = (is_lowpfd && (casc_r < 12'h004)) ||
                       (is_frac && !sdm_pd_r && (frac_r >= mod_r));
  wire pll_fb_pkg::ratio_t int_ratio = at_least({5'h00, int_div_r}, `RATIO_ONE);
  wire pll_fb_pkg::ratio_t carry_ratio = int_ratio + {12'h000, sdm.carry};
  wire pll_fb_pkg::ratio_t m0_ratio = at_least({9'h000, vco_div_r[3:0]}, `VCO_DIV_MIN);
  wire pll_fb_pkg::ratio_t casc_ratio = at_least({1'b0, casc_r}, `CASC_DIV_MIN);
  wire pll_fb_pkg::ratio_t zd_ratio = at_least({6'h00, zd_div_r}, `RATIO_ONE);

  // Fractional: integer plus carry, stage B passes through. Low rate: the
  // product of integer and cascade. Zero delay: primary VCO divider then
  // zero-delay channel divider, whose output leaves only as FB_PULSE.
  assign stage_a.ratio = is_frac ? carry_ratio :
                         is_lowpfd ? int_ratio : m0_ratio;
  assign stage_b.ratio = is_frac ? `RATIO_ONE :
                         is_lowpfd ? casc_ratio : zd_ratio;
  assign stage_a.step_in = vco_rise;
  assign stage_b.step_in = stage_a.step_out;
  assign stage_a.sync_clr = is_zd && sync_rise;
  assign stage_b.sync_clr = is_zd && sync_rise;

  // Only the fractional loop runs the modulator; zero fraction keeps it powered.
  assign sdm.en = is_frac && !sdm_pd_r;
  assign sdm.step = stage_b.step_out;
  assign sdm.frac = frac_r;
  assign sdm.modulus = mod_r;

  pulse_divider u_stage_a (
    .clk(MCLK),
    .rst(RESET),
    .lnk(stage_a)
  );

  pulse_divider u_stage_b (
    .clk(MCLK),
    .rst(RESET),
    .lnk(stage_b)
  );

  sdm_accum u_sdm (
    .clk(MCLK),
    .rst(RESET),
    .lnk(sdm)
  );

  // ****************************************************************
  // Reference scaling and loop filter overrides
  // ****************************************************************
  logic [5:0] ref_cnt_r;
  wire logic [5:0] ref_ratio = (ref_div_r == 6'h00) ? 6'h01 : ref_div_r;
  wire logic ref_wrap = ref_rise && (ref_cnt_r >= ref_ratio - 6'h01);
  wire logic ref_pulse = doubler_r ? (ref_rise || ref_fall) : ref_wrap;

  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      ref_cnt_r <= '0;
      PFD_REF_PULSE <= 1'b0;
      FB_PULSE <= 1'b0;
      CP_CURRENT <= 9'h000;
      RZERO_SHORT <= 1'b0;
      CPOLE_100PF <= 1'b0;
      SDM_POWERDOWN <= 1'b0;
    end
    else
    begin
      if (ref_rise)
        ref_cnt_r <= ref_wrap ? 6'h00 : ref_cnt_r + 6'h01;
      PFD_REF_PULSE <= ref_pulse;
      FB_PULSE <= stage_b.step_out;
      CP_CURRENT <= is_lowpfd ? `CP_FORCED_CODE : {1'b0, cp_r};
      RZERO_SHORT <= is_lowpfd;
      CPOLE_100PF <= is_lowpfd;
      SDM_POWERDOWN <= !sdm.en;
    end
  end

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  wire logic [7:0] status = {3'b000, cfg_err, sdm.en, mode_bits};
  wire logic [7:0] rd_byte =
    (idx_r == `IDX_LOOP_CTRL) ? {ctrl_spare_r, doubler_r, mode_code, sdm_pd_r} :
    (idx_r == `IDX_CP_CURRENT) ? cp_r :
    (idx_r == `IDX_REF_DIV) ? {2'b00, ref_div_r} :
    (idx_r == `IDX_CASC_LOW) ? casc_r[7:0] :
    (idx_r == `IDX_CASC_HIGH) ? {4'h0, casc_r[11:8]} :
    (idx_r == `IDX_VCO_DIV) ? vco_div_r :
    (idx_r == `IDX_FRAC_B0) ? frac_r[7:0] :
    (idx_r == `IDX_FRAC_B1) ? frac_r[15:8] :
    (idx_r == `IDX_FRAC_B2) ? frac_r[23:16] :
    (idx_r == `IDX_MOD_B0) ? mod_r[7:0] :
    (idx_r == `IDX_MOD_B1) ? mod_r[15:8] :
    (idx_r == `IDX_MOD_B2) ? mod_r[23:16] :
    (idx_r == `IDX_INT_DIV) ? int_div_r :
    (idx_r == `IDX_ZD_DIV) ? {1'b0, zd_div_r} :
    (idx_r == `IDX_STATUS) ? status : 8'h00;

  // Reads take one wait state so a write just before is always seen.
  always_comb
  begin
    case (bus_r)
      pll_fb_pkg::BUS_RD_FETCH:
        bus_nxt = pll_fb_pkg::BUS_RD_DONE;
      pll_fb_pkg::BUS_IDLE, pll_fb_pkg::BUS_WRITE, pll_fb_pkg::BUS_RD_DONE:
        bus_nxt = !accept ? pll_fb_pkg::BUS_IDLE :
                  HWRITE ? pll_fb_pkg::BUS_WRITE : pll_fb_pkg::BUS_RD_FETCH;
      default:
        bus_nxt = pll_fb_pkg::BUS_IDLE;
    endcase
  end

  assign HREADYOUT = bus_r != pll_fb_pkg::BUS_RD_FETCH;
  assign HRESP = 1'b0;
  assign HRDATA = rdata_r;

  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      bus_r <= pll_fb_pkg::BUS_IDLE;
      idx_r <= '0;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      bus_r <= bus_nxt;
      if (accept && HREADYOUT)
        idx_r <= HADDR[11:2];
      if (bus_r == pll_fb_pkg::BUS_RD_FETCH)
        rdata_r <= {24'h00_0000, is_mapped(idx_r) ? rd_byte : 8'h00};
    end
  end

endmodule

// file: pll_fb_ctrl_asserts.sv
`timescale 1ns/1ps

// ****************************************************************
// Port-level checks of the feedback controller
// ****************************************************************
module pll_fb_ctrl_asserts (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic FB_PULSE,
  input wire logic PFD_REF_PULSE,
  input wire logic [8:0] CP_CURRENT,
  input wire logic RZERO_SHORT,
  input wire logic CPOLE_100PF,
  input wire logic SDM_POWERDOWN
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RESET);

  wire taken = HSEL && HTRANS[1] && HREADY;

  chk_cp_forced: assert property (RZERO_SHORT |-> CP_CURRENT == 9'h100)
    else $error("charge pump code not forced in low rate loop");
  chk_filter_pair: assert property (CPOLE_100PF == RZERO_SHORT)
    else $error("pole capacitor and zero short disagree");
  chk_lowrate_integer: assert property (RZERO_SHORT |-> SDM_POWERDOWN)
    else $error("modulator active outside the fractional loop");
  chk_fb_single: assert property (FB_PULSE |=> !FB_PULSE [*2])
    else $error("feedback pulse longer than one cycle");
  chk_ref_single: assert property (PFD_REF_PULSE |=> !PFD_REF_PULSE)
    else $error("reference pulse longer than one cycle");
  chk_read_wait: assert property (taken && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read data phase not one wait state");
  chk_write_ready: assert property (taken && HWRITE |=> HREADYOUT)
    else $error("write data phase stalled");
  chk_rdata_byte: assert property (HRDATA[31:8] == 24'h00_0000)
    else $error("upper read data bits not zero");
  chk_resp_okay: assert property (HRESP == 1'b0)
    else $error("bus response not okay");
endmodule

// file: pll_fb_ctrl_tb_top.sv
`timescale 1ns/1ps
`include "pll_fb_params.svh"
`define CHECK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin fails++; \
  $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end

module pll_fb_ctrl_tb_top;
  typedef struct packed {logic wr; logic [9:0] idx; logic [7:0] d; logic [7:0] ex;} row_t;
  logic MCLK = 1'b0;
  logic RESET = 1'b1;
  logic HSEL = 1'b0;
  logic [11:0] HADDR = 12'h000;
  logic [1:0] HTRANS = 2'b00;
  logic HWRITE = 1'b0;
  logic [31:0] HWDATA = 32'h0000_0000;
  logic CHAN_SYNC = 1'b0;
  logic [31:0] HRDATA;
  logic HREADYOUT, HRESP, VCO_CLK, REF_CLK, FB_PULSE, PFD_REF_PULSE;
  logic [8:0] CP_CURRENT;
  logic RZERO_SHORT, CPOLE_100PF, SDM_POWERDOWN;
  logic [31:0] rd;
  int fails = 0;
  int samples_checked = 0;
  int s;
  int c;
  row_t rows [20] = '{
    '{1'b0, `IDX_CP_CURRENT, 8'h00, 8'h8D}, '{1'b0, `IDX_REF_DIV, 8'h00, 8'h01},
    '{1'b0, `IDX_CASC_LOW, 8'h00, 8'h04}, '{1'b0, `IDX_CASC_HIGH, 8'h00, 8'h00},
    '{1'b0, `IDX_VCO_DIV, 8'h00, 8'h44}, '{1'b0, `IDX_INT_DIV, 8'h00, 8'h32},
    '{1'b0, `IDX_ZD_DIV, 8'h00, 8'h01}, '{1'b0, `IDX_MOD_B0, 8'h00, 8'h01},
    '{1'b0, `IDX_LOOP_CTRL, 8'h00, 8'h00}, '{1'b1, `IDX_CP_CURRENT, 8'h5A, 8'h5A},
    '{1'b1, `IDX_REF_DIV, 8'hFF, 8'h3F}, '{1'b1, `IDX_REF_DIV, 8'h02, 8'h02},
    '{1'b1, `IDX_CASC_HIGH, 8'hFF, 8'h0F}, '{1'b1, `IDX_CASC_HIGH, 8'h00, 8'h00},
    '{1'b1, 10'h200, 8'hAA, 8'h00}, '{1'b1, `IDX_INT_DIV, 8'h0C, 8'h0C},
    '{1'b1, `IDX_VCO_DIV, 8'h42, 8'h42}, '{1'b1, `IDX_ZD_DIV, 8'h03, 8'h03},
    '{1'b1, `IDX_LOOP_CTRL, 8'hF6, 8'hF0}, '{1'b1, `IDX_STATUS, 8'hFF, 8'h09}};

  always #12.5 MCLK = ~MCLK;

  pll_fb_ctrl pll_fb_ctrl_inst (.MCLK(MCLK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'b010), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .VCO_CLK(VCO_CLK),
    .REF_CLK(REF_CLK), .CHAN_SYNC(CHAN_SYNC), .FB_PULSE(FB_PULSE),
    .PFD_REF_PULSE(PFD_REF_PULSE), .CP_CURRENT(CP_CURRENT), .RZERO_SHORT(RZERO_SHORT),
    .CPOLE_100PF(CPOLE_100PF), .SDM_POWERDOWN(SDM_POWERDOWN));

  vco_ref_model vco_ref_model_inst (.MCLK(MCLK), .RESET(RESET), .VCO_CLK(VCO_CLK),
    .REF_CLK(REF_CLK));

  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Waits for the sampled ready; a stuck slave ends the run.
  task automatic wait_ready;
    int n;
    n = 0;
    do
    begin
      @(posedge MCLK);
      n++;
    end
    while (HREADYOUT !== 1'b1 && n < 50);
    if (HREADYOUT !== 1'b1)
    begin
      fails++;
      test_done();
    end
  endtask

  task automatic xfer(input logic wr, input logic [9:0] idx, input logic [7:0] d);
    @(posedge MCLK);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HWRITE <= wr;
    HADDR <= {idx, 2'b00};
    wait_ready();
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= {24'h00_0000, d};
    wait_ready();
    rd = HRDATA;
  endtask

  task automatic wait_pulse(input logic sel, output int cnt);
    cnt = 0;
    do
    begin
      @(posedge MCLK);
      cnt++;
    end
    while ((sel ? PFD_REF_PULSE : FB_PULSE) !== 1'b1 && cnt < 3000);
    if ((sel ? PFD_REF_PULSE : FB_PULSE) !== 1'b1)
    begin
      fails++;
      test_done();
    end
  endtask

  // The first two pulses after a change are skipped while the dividers settle.
  task automatic gap_sum(input logic sel, input int n, output int sum);
    int k;
    int g;
    sum = 0;
    for (k = 0; k <= n + 1; k++)
    begin
      wait_pulse(sel, g);
      if (k > 1)
        sum += g;
    end
  endtask

  initial
  begin
    repeat (8) @(posedge MCLK);
    RESET <= 1'b0;
    repeat (2) @(posedge MCLK);
    `CHECK("cp_reset", 9'h08D, CP_CURRENT)
    foreach (rows[i])
    begin
      if (rows[i].wr)
        xfer(1'b1, rows[i].idx, rows[i].d);
      xfer(1'b0, rows[i].idx, 8'h00);
      `CHECK("register", rows[i].ex, rd[7:0])
    end
    // ****************************************************************
    // Loop configurations
    // ****************************************************************
    `CHECK("sdm_pd", 1'b0, SDM_POWERDOWN)
    `CHECK("cp", 9'h05A, CP_CURRENT)
    gap_sum(1'b0, 2, s);
    `CHECK("zero_frac", 192, s)
    gap_sum(1'b1, 1, s);
    `CHECK("ref_div", 80, s)
    xfer(1'b1, `IDX_LOOP_CTRL, 8'hF8);
    gap_sum(1'b1, 2, s);
    `CHECK("doubler", 40, s)
    xfer(1'b1, `IDX_INT_DIV, 8'h0F);
    // Fraction 1/3 scaled up so that the modulus is as large as it can be.
    for (int b = 0; b < 3; b++)
    begin
      xfer(1'b1, 10'(`IDX_FRAC_B0 + b), 8'h55);
      xfer(1'b1, 10'(`IDX_MOD_B0 + b), 8'hFF);
    end
    xfer(1'b1, `IDX_LOOP_CTRL, 8'hF0);
    gap_sum(1'b0, 3, s);
    `CHECK("fraction", 368, s)
    xfer(1'b1, `IDX_LOOP_CTRL, 8'hF1);
    // Registered outputs follow a register write one edge after it lands.
    repeat (2) @(posedge MCLK);
    `CHECK("sdm_pd", 1'b1, SDM_POWERDOWN)
    gap_sum(1'b0, 3, s);
    `CHECK("frac_off", 360, s)
    xfer(1'b1, `IDX_INT_DIV, 8'h0C);
    xfer(1'b1, `IDX_LOOP_CTRL, 8'hF3);
    repeat (2) @(posedge MCLK);
    `CHECK("cp_forced", 9'h100, CP_CURRENT)
    `CHECK("rzero", 1'b1, RZERO_SHORT)
    `CHECK("cpole", 1'b1, CPOLE_100PF)
    gap_sum(1'b0, 1, s);
    `CHECK("low_rate", 384, s)
    xfer(1'b0, `IDX_STATUS, 8'h00);
    `CHECK("mode", 3'b010, rd[2:0])
    xfer(1'b1, `IDX_LOOP_CTRL, 8'hF5);
    gap_sum(1'b0, 2, s);
    `CHECK("zero_delay", 96, s)
    xfer(1'b1, `IDX_LOOP_CTRL, 8'hF7);
    gap_sum(1'b0, 1, s);
    `CHECK("reserved", 48, s)
    xfer(1'b0, `IDX_STATUS, 8'h00);
    `CHECK("mode", 3'b100, rd[2:0])
    // A sync 20 cycles into a 48-cycle period must restart the count and stretch that period.
    wait_pulse(1'b0, c);
    repeat (20) @(posedge MCLK);
    CHAN_SYNC <= 1'b1;
    repeat (4) @(posedge MCLK);
    CHAN_SYNC <= 1'b0;
    wait_pulse(1'b0, c);
    `CHECK("restart", 1'b1, (c + 24 > 56 && c + 24 < 90))
    RESET <= 1'b1;
    repeat (8) @(posedge MCLK);
    RESET <= 1'b0;
    repeat (2) @(posedge MCLK);
    `CHECK("cp_reset", 9'h08D, CP_CURRENT)
    `CHECK("rzero_reset", 1'b0, RZERO_SHORT)
    `CHECK("hresp", 1'b0, HRESP)
    xfer(1'b0, `IDX_LOOP_CTRL, 8'h00);
    `CHECK("loop_reset", 8'h00, rd[7:0])
    test_done();
  end
endmodule

bind pll_fb_ctrl pll_fb_ctrl_asserts pll_fb_ctrl_asserts_inst (.MCLK(MCLK), .RESET(RESET),
  .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .FB_PULSE(FB_PULSE), .PFD_REF_PULSE(PFD_REF_PULSE),
  .CP_CURRENT(CP_CURRENT), .RZERO_SHORT(RZERO_SHORT), .CPOLE_100PF(CPOLE_100PF),
  .SDM_POWERDOWN(SDM_POWERDOWN));

// file: pll_fb_links.sv
`timescale 1ns/1ps

interface div_link;
  logic step_in;
  logic sync_clr;
  pll_fb_pkg::ratio_t ratio;
  logic step_out;
  modport stage(input step_in, input sync_clr, input ratio, output step_out);
  modport ctl(output step_in, output sync_clr, output ratio, input step_out);
endinterface

interface sdm_link;
  logic en;
  logic step;
  pll_fb_pkg::word24_t frac;
  pll_fb_pkg::word24_t modulus;
  logic carry;
  modport acc(input en, input step, input frac, input modulus, output carry);
  modport ctl(output en, output step, output frac, output modulus, input carry);
endinterface

// file: pll_fb_params.svh
`ifndef PLL_FB_PARAMS_SVH
`define PLL_FB_PARAMS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define IDX_LOOP_CTRL 10'h101
`define IDX_CP_CURRENT 10'h102
`define IDX_REF_DIV 10'h105
`define IDX_CASC_LOW 10'h10E
`define IDX_CASC_HIGH 10'h10F
`define IDX_VCO_DIV 10'h121
`define IDX_FRAC_B0 10'h130
`define IDX_FRAC_B1 10'h131
`define IDX_FRAC_B2 10'h132
`define IDX_MOD_B0 10'h133
`define IDX_MOD_B1 10'h134
`define IDX_MOD_B2 10'h135
`define IDX_INT_DIV 10'h136
`define IDX_ZD_DIV 10'h137
`define IDX_STATUS 10'h13F

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_SDM_PD 0
`define BIT_MODE_LO 1
`define BIT_MODE_HI 2
`define BIT_DOUBLER 3

// ****************************************************************
// Reset values and fixed codes
// ****************************************************************
`define RST_LOOP_CTRL 8'h00
`define RST_CP_CURRENT 8'h8D
`define RST_REF_DIV 6'h01
`define RST_CASC_DIV 12'h004
`define RST_VCO_DIV 8'h44
`define RST_FRAC 24'h00_0000
`define RST_MOD 24'h00_0001
`define RST_INT_DIV 8'h32
`define RST_ZD_DIV 7'h01
`define CP_FORCED_CODE 9'h100
`define CASC_DIV_MIN 13'h0004
`define VCO_DIV_MIN 13'h0002
`define RATIO_ONE 13'h0001

`endif

// file: pll_fb_pkg.sv
package pll_fb_pkg;

  typedef logic [12:0] ratio_t;
  typedef logic [23:0] word24_t;

  typedef enum logic [2:0]
  {
    LOOP_FRAC = 3'b001,
    LOOP_LOWPFD = 3'b010,
    LOOP_ZD = 3'b100
  } loop_mode_t;

  typedef enum logic [3:0]
  {
    BUS_IDLE = 4'b0001,
    BUS_WRITE = 4'b0010,
    BUS_RD_FETCH = 4'b0100,
    BUS_RD_DONE = 4'b1000
  } bus_state_t;

endpackage

// file: pulse_divider.sv
`timescale 1ns/1ps

// ****************************************************************
// Counts input steps and emits one step per ratio inputs
// ****************************************************************
module pulse_divider (
  input wire logic clk,
  input wire logic rst,
  div_link.stage lnk
);

  pll_fb_pkg::ratio_t cnt_r;
  logic step_out_r;
  wire logic wrap;

  // The ratio is compared on every input step, so a new ratio at or below
  // the count wraps on the next step and cuts the current period short.
  assign wrap = lnk.step_in && (cnt_r >= (lnk.ratio - 13'h0001));
  assign lnk.step_out = step_out_r;

  always_ff @(posedge clk)
  begin
    if (rst || lnk.sync_clr)
    begin
      cnt_r <= '0;
      step_out_r <= 1'b0;
    end
    else
    begin
      step_out_r <= wrap;
      if (lnk.step_in)
        cnt_r <= wrap ? '0 : cnt_r + 13'h0001;
    end
  end

endmodule

// file: sdm_accum.sv
`timescale 1ns/1ps

// ****************************************************************
// Fraction accumulator: one carry per overflow of fraction/modulus
// ****************************************************************
module sdm_accum (
  input wire logic clk,
  input wire logic rst,
  sdm_link.acc lnk
);

  pll_fb_pkg::word24_t acc_r;
  logic carry_r;
  wire logic [24:0] sum;
  wire logic [24:0] wrapped;
  wire logic over;

  assign sum = {1'b0, acc_r} + {1'b0, lnk.frac};
  assign over = sum >= {1'b0, lnk.modulus};
  assign wrapped = sum - {1'b0, lnk.modulus};
  assign lnk.carry = carry_r;

  // A disabled modulator holds a zero phase so the fraction acts as zero.
  always_ff @(posedge clk)
  begin
    if (rst || !lnk.en)
    begin
      acc_r <= '0;
      carry_r <= 1'b0;
    end
    else if (lnk.step)
    begin
      acc_r <= over ? wrapped[23:0] : sum[23:0];
      carry_r <= over;
    end
  end

endmodule

// file: vco_ref_model.sv
`timescale 1ns/1ps

// ****************************************************************
// Oscillator and reference source
// ****************************************************************
module vco_ref_model #(
  parameter int VCO_HALF = 4,
  parameter int REF_HALF = 20
) (
  input wire logic MCLK,
  input wire logic RESET,
  output logic VCO_CLK,
  output logic REF_CLK
);
  int vco_cnt;
  int ref_cnt;

  // The oscillator stays at MCLK/8 so no edge is lost in the synchroniser.
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      vco_cnt <= 0;
      ref_cnt <= 0;
      VCO_CLK <= 1'b0;
      REF_CLK <= 1'b0;
    end
    else
    begin
      vco_cnt <= (vco_cnt == VCO_HALF - 1) ? 0 : vco_cnt + 1;
      ref_cnt <= (ref_cnt == REF_HALF - 1) ? 0 : ref_cnt + 1;
      if (vco_cnt == VCO_HALF - 1)
        VCO_CLK <= !VCO_CLK;
      if (ref_cnt == REF_HALF - 1)
        REF_CLK <= !REF_CLK;
    end
  end
endmodule
